// ===== rtl/lpc_ctrl.sv
`timescale 1ns/10ps
module lpc_ctrl #(
    parameter int DMA_CH = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Software mode requests
    input wire logic stop_req,
    input wire logic [1:0] stop_control_setting,
    input wire logic reduced_power_run,
    input wire logic compute_op_request,
    input wire logic compute_auto_exit,
    input wire logic [DMA_CH-1:0] dma_wake_en,
    input wire logic wait_mode,
    output logic compute_op_acknowledge,
    output logic stop_abort,
    input wire logic stop_abort_clr,
    output logic in_low_power,
    // Wake sources
    input wire logic irq_async_sys,
    input wire logic irq_async_any,
    input wire logic irq_sync_bus,
    input wire logic irq_edge,
    input wire logic irq_core_exc,
    output logic irq_service_ok,
    input wire logic [DMA_CH-1:0] dma_req,
    input wire logic dma_busy,
    // Stop handshakes
    output logic mst_stop_req,
    input wire logic mst_stop_ack,
    output logic slv_stop_req,
    input wire logic slv_stop_ack,
    output logic bus_slv_stop_req,
    output logic gen_low_req,
    output logic pmc_low_req,
    input wire logic pmc_ready,
    // Clock gates
    output logic core_clk_en,
    output logic sys_clk_en,
    output logic bus_clk_en,
    // Compute operation access control
    output logic bridge_space_err,
    output logic flash_reg_en,
    output logic io_port_input_valid,
    // Doze
    input wire logic [31:0] periph_doze_en,
    input wire logic flash_doze_en,
    output logic [31:0] periph_dozed,
    output logic flash_dozed
);

    ////////////////////////////////////////////////////////////////////////
    logic rst_s1;
    logic rst_s2;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    lpc_pkg::lpc_state_e state;
    logic compute_mode;
    logic [1:0] mode_sel;
    logic from_rpr;
    logic [7:0] settle_cnt;

    logic dma_wake;
    logic wake_irq;
    logic cpo_exit;
    logic low_gen;
    assign dma_wake = |(dma_req & dma_wake_en);
    // Stop and low stop move generator and regulator; partial stops leave them in run
    assign low_gen = !compute_mode
        && (mode_sel == lpc_pkg::STOP_FULL || mode_sel == lpc_pkg::STOP_LOW);
    assign cpo_exit = compute_mode && (!compute_op_request || (compute_auto_exit && irq_async_any));

    always_comb begin
        if (compute_mode)
            wake_irq = 1'b0;
        else if (mode_sel == lpc_pkg::STOP_BUS_ALIVE)
            wake_irq = irq_async_sys || irq_sync_bus;
        else
            wake_irq = irq_async_any;
    end

    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            state <= lpc_pkg::LPC_RUN;
        end else begin
            unique case (state)
                lpc_pkg::LPC_RUN: begin
                    // Compute must be left first, so a stop is taken only from plain run
                    if (compute_op_request)
                        state <= lpc_pkg::LPC_ENT_MST;
                    else if (stop_req)
                        state <= lpc_pkg::LPC_ENT_MST;
                end
                lpc_pkg::LPC_ENT_MST: begin
                    if (dma_wake)
                        state <= lpc_pkg::LPC_WAKE;
                    else if (mst_stop_ack)
                        state <= lpc_pkg::LPC_ENT_SLV;
                end
                lpc_pkg::LPC_ENT_SLV: begin
                    if (dma_wake)
                        state <= lpc_pkg::LPC_WAKE;
                    else if (slv_stop_ack)
                        state <= low_gen ? lpc_pkg::LPC_ENT_GEN : lpc_pkg::LPC_LOW;
                end
                lpc_pkg::LPC_ENT_GEN: begin
                    if (dma_wake)
                        state <= lpc_pkg::LPC_WAKE_UP;
                    else
                        state <= lpc_pkg::LPC_LOW;
                end
                lpc_pkg::LPC_LOW: begin
                    if (wake_irq || cpo_exit)
                        state <= lpc_pkg::LPC_EXIT;
                    else if (dma_wake)
                        state <= low_gen ? lpc_pkg::LPC_WAKE_UP : lpc_pkg::LPC_WAKE;
                end
                lpc_pkg::LPC_WAKE_UP: begin
                    if (pmc_ready)
                        state <= lpc_pkg::LPC_WAKE;
                end
                lpc_pkg::LPC_WAKE: begin
                    // Request that never drops keeps us here until a full exit
                    if (wake_irq || irq_async_any && !compute_mode || cpo_exit)
                        state <= lpc_pkg::LPC_EXIT;
                    else if (!dma_wake && !dma_busy)
                        state <= lpc_pkg::LPC_ENT_MST;
                end
                lpc_pkg::LPC_EXIT: begin
                    if (compute_mode && from_rpr)
                        state <= lpc_pkg::LPC_SETTLE;
                    else
                        state <= lpc_pkg::LPC_RUN;
                end
                lpc_pkg::LPC_SETTLE: begin
                    if (settle_cnt == 8'(lpc_pkg::PWR_SETTLE_CYC - 1) && pmc_ready)
                        state <= lpc_pkg::LPC_RUN;
                end
                default: state <= lpc_pkg::LPC_RUN;
            endcase
        end
    end

    // Mode latched on entry from run
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            compute_mode <= 1'b0;
            mode_sel <= lpc_pkg::STOP_FULL;
            from_rpr <= 1'b0;
        end else if (state == lpc_pkg::LPC_RUN) begin
            compute_mode <= compute_op_request;
            from_rpr <= reduced_power_run;
            mode_sel <= (!compute_op_request && reduced_power_run && stop_control_setting == lpc_pkg::STOP_FULL)
                ? lpc_pkg::STOP_LOW : stop_control_setting;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2)
            settle_cnt <= 8'h00;
        else if (state == lpc_pkg::LPC_SETTLE)
            settle_cnt <= (settle_cnt == 8'(lpc_pkg::PWR_SETTLE_CYC - 1)) ? settle_cnt : settle_cnt + 8'h01;
        else
            settle_cnt <= 8'h00;
    end

    // Set wins over clear
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2)
            stop_abort <= 1'b0;
        else if (dma_wake && (state == lpc_pkg::LPC_ENT_MST || state == lpc_pkg::LPC_ENT_SLV
                 || state == lpc_pkg::LPC_ENT_GEN))
            stop_abort <= 1'b1;
        else if (stop_abort_clr)
            stop_abort <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    logic entering;
    logic asleep;
    logic active_low;
    assign entering = state == lpc_pkg::LPC_ENT_MST || state == lpc_pkg::LPC_ENT_SLV
        || state == lpc_pkg::LPC_ENT_GEN;
    assign asleep = state == lpc_pkg::LPC_ENT_GEN || state == lpc_pkg::LPC_LOW;
    assign active_low = state != lpc_pkg::LPC_RUN && state != lpc_pkg::LPC_SETTLE;

    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            mst_stop_req <= 1'b0;
            slv_stop_req <= 1'b0;
            bus_slv_stop_req <= 1'b0;
            gen_low_req <= 1'b0;
            pmc_low_req <= 1'b0;
        end else begin
            mst_stop_req <= entering || asleep;
            slv_stop_req <= state == lpc_pkg::LPC_ENT_SLV || asleep;
            bus_slv_stop_req <= (state == lpc_pkg::LPC_ENT_SLV || asleep)
                && (compute_mode || mode_sel != lpc_pkg::STOP_BUS_ALIVE);
            gen_low_req <= asleep && low_gen;
            pmc_low_req <= asleep && low_gen;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            core_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
            bus_clk_en <= 1'b1;
        end else begin
            // Core clock stays off through DMA wakeups out of stops
            core_clk_en <= compute_mode || !(asleep || state == lpc_pkg::LPC_WAKE_UP
                || state == lpc_pkg::LPC_WAKE) || state == lpc_pkg::LPC_RUN;
            sys_clk_en <= !(state == lpc_pkg::LPC_LOW && !compute_mode);
            bus_clk_en <= !(state == lpc_pkg::LPC_LOW && !compute_mode
                && mode_sel != lpc_pkg::STOP_BUS_ALIVE);
        end
    end

    logic settle_done;
    assign settle_done = settle_cnt == 8'(lpc_pkg::PWR_SETTLE_CYC - 1) && pmc_ready;

    // Reduced power exit holds the acknowledge until the regulator has settled
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2)
            compute_op_acknowledge <= 1'b0;
        else
            compute_op_acknowledge <= compute_mode
                && ((state == lpc_pkg::LPC_LOW && !cpo_exit && !dma_wake)
                || (from_rpr && compute_op_acknowledge && ((state == lpc_pkg::LPC_LOW && cpo_exit)
                || state == lpc_pkg::LPC_EXIT || (state == lpc_pkg::LPC_SETTLE && !settle_done))));
    end

    assign in_low_power = active_low;
    // Bridge space stays blocked until the state is LPC_RUN or LPC_WAKE, software polls acknowledge
    assign bridge_space_err = compute_mode && state != lpc_pkg::LPC_RUN
        && state != lpc_pkg::LPC_WAKE;
    assign flash_reg_en = !bridge_space_err;
    assign io_port_input_valid = !(compute_mode && asleep);
    assign irq_service_ok = !(compute_mode && active_low) || irq_edge || irq_core_exc;

    // Doze covers wait, stop entry, wakeups and compute
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            periph_dozed <= 32'h0000_0000;
            flash_dozed <= 1'b0;
        end else begin
            periph_dozed <= (wait_mode || active_low) ? periph_doze_en : 32'h0000_0000;
            flash_dozed <= (wait_mode || active_low) && flash_doze_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    bus_alive_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        $rose(state == lpc_pkg::LPC_LOW) && !compute_mode && mode_sel == lpc_pkg::STOP_BUS_ALIVE
        |=> bus_clk_en && !sys_clk_en) else $error("bus clock lost in bus-alive stop");
    full_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_LOW && !compute_mode && mode_sel == lpc_pkg::STOP_FULL_GATE
        |=> !bus_clk_en || state != lpc_pkg::LPC_LOW) else $error("bus clock running in full gate");
    abort_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        entering && dma_wake |=> stop_abort) else $error("abort flag not set");
    wake_core_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_WAKE && !compute_mode |=> !core_clk_en) else $error("core clock on in wakeup");
    compute_core_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        compute_mode && state != lpc_pkg::LPC_RUN |=> core_clk_en) else $error("core clock off in compute");
    ack_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        compute_op_acknowledge && !compute_op_request && !from_rpr |=> !compute_op_acknowledge)
        else $error("acknowledge late in run exit");
    stage_order_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        $rose(slv_stop_req) |-> mst_stop_req) else $error("slaves stopped before masters");
    doze_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        wait_mode |=> periph_dozed == $past(periph_doze_en)) else $error("doze not applied");
    bridge_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        compute_op_acknowledge |-> bridge_space_err) else $error("bridge open in compute");

    bus_alive_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_LOW && !compute_mode && mode_sel == lpc_pkg::STOP_BUS_ALIVE
        |=> !bus_slv_stop_req && !gen_low_req && !pmc_low_req)
        else $error("bus side stopped in bus-alive stop");

    gate_gen_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_LOW && !compute_mode && mode_sel == lpc_pkg::STOP_FULL_GATE
        |=> bus_slv_stop_req && !gen_low_req && !pmc_low_req)
        else $error("full gate stop wrong requests");

    masked_dma_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_LOW && !wake_irq && !cpo_exit && !dma_wake
        |=> state == lpc_pkg::LPC_LOW)
        else $error("left stop without enabled source");

    wake_up_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_WAKE_UP && !compute_mode
        |=> !mst_stop_req && !slv_stop_req && !gen_low_req && !core_clk_en)
        else $error("stop not released on wakeup");

    wake_cpo_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_WAKE && compute_mode
        |=> core_clk_en && !mst_stop_req && !slv_stop_req)
        else $error("compute wakeup wrong outputs");

    hold_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_WAKE && dma_wake && !wake_irq && !irq_async_any && !cpo_exit
        |=> state == lpc_pkg::LPC_WAKE)
        else $error("woken state left early");

    irq_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_WAKE && !compute_mode && (wake_irq || irq_async_any)
        |=> state == lpc_pkg::LPC_EXIT)
        else $error("no exit on irq in wakeup");

    cpo_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_RUN && compute_op_request
        |=> state == lpc_pkg::LPC_ENT_MST && compute_mode)
        else $error("compute entry not started");

    ack_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        compute_op_acknowledge && from_rpr && state == lpc_pkg::LPC_EXIT
        |=> compute_op_acknowledge)
        else $error("acknowledge dropped before settle");

    port_in_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        compute_mode && state == lpc_pkg::LPC_LOW
        |-> !io_port_input_valid)
        else $error("port input marked valid");

    level_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        compute_mode && state == lpc_pkg::LPC_LOW && !irq_edge && !irq_core_exc
        |-> !irq_service_ok)
        else $error("level irq serviced in compute");

    doze_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        in_low_power
        |=> periph_dozed == $past(periph_doze_en))
        else $error("doze not applied in stop");

    mst_first_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        state == lpc_pkg::LPC_ENT_MST
        |=> !slv_stop_req)
        else $error("slaves asked during master stage");

    abort_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        stop_abort && !stop_abort_clr
        |=> stop_abort)
        else $error("abort flag lost");

endmodule : lpc_ctrl

// ===== inc/lpc_pkg.sv
// Overview of operation
// - Bus-alive partial stop gates core and system clocks, bus clock keeps running.
// - Bus-alive partial stop stops system-clocked parties; bus slaves, generator, regulator stay run.
// - Bus-alive partial stop exits on reset, system async irq or bus sync irq.
// - Enabled async DMA request leaves partial stop for the transfer, then returns.
// - Full-gate partial stop gates system and bus clocks, stops masters and slaves; generator, regulator stay run.
// - Full-gate partial stop exits only on reset, async irq, or DMA wakeup.
// - DMA wakeup enabled per channel; works in compute, partial stops, stop, low stop.
// - DMA wakeup from stop restores power, clocks, releases stop; core clock stays off.
// - DMA wakeup in compute enables clocks and releases stop; core clock stays on.
// - After DMA request drops and transfer ends, re-enter: masters, then slaves, then generator.
// - DMA request that never drops keeps the woken state until full exit.
// - DMA request during entry aborts it, sets stop-abort flag, entry restarts later.
// - Interrupt during DMA wakeup gives immediate full exit; optional in compute.
// - Compute operation keeps CPU clocked with memory access, stops other parties.
// - Compute entry uses staged stop sequence; modules act as stop or low stop.
// - In compute, bridge space errors, flash registers off, private space open.
// - In compute, port input reads invalid; port output writes still drive pins.
// - Request bit one enters compute, zero exits; optional auto-exit on interrupt.
// - In compute only core exceptions and edge interrupts serviced without exit.
// - Acknowledge rises at entry end; drops at once in run, after power settle otherwise.
// - Doze bits disable peripherals and flash in wait, stop, wakeup and compute.
package lpc_pkg;
    localparam logic [1:0] STOP_FULL = 2'h0;
    localparam logic [1:0] STOP_BUS_ALIVE = 2'h1;
    localparam logic [1:0] STOP_FULL_GATE = 2'h2;
    localparam logic [1:0] STOP_LOW = 2'h3;
    // Power settle time on exit from compute in reduced power run
    localparam int PWR_SETTLE_NS = 40;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [3:0] {
        LPC_RUN, LPC_ENT_MST, LPC_ENT_SLV, LPC_ENT_GEN, LPC_LOW, LPC_WAKE_UP, LPC_WAKE, LPC_EXIT, LPC_SETTLE
    } lpc_state_e;
endpackage : lpc_pkg

// ===== test/lpc_far_model.sv
`timescale 1ns/10ps
// Stand-in for the bus masters, slaves and power controller on the far side
module lpc_far_model (
    // Clock
    input wire logic clk_sys,
    // Requests from the controller, plus the bench's slow select
    input wire logic mst_stop_req,
    input wire logic slv_stop_req,
    input wire logic pmc_low_req,
    input wire logic slow,
    // Answers
    output logic mst_stop_ack,
    output logic slv_stop_ack,
    output logic pmc_ready
);
    logic [7:0] mst_d = 8'h00;
    logic [7:0] slv_d = 8'h00;
    logic [7:0] pmc_d = 8'h00;

    always_ff @(posedge clk_sys) begin
        mst_d <= {mst_d[6:0], mst_stop_req};
        slv_d <= {slv_d[6:0], slv_stop_req};
        pmc_d <= {pmc_d[6:0], pmc_low_req};
    end
    // Slow mode makes the controller wait eight cycles on every handshake
    assign mst_stop_ack = slow ? mst_d[7] : mst_d[0];
    assign slv_stop_ack = slow ? slv_d[7] : slv_d[0];
    // Regulator only reports ready once the low request has been gone a while
    assign pmc_ready = slow ? ~|pmc_d : ~pmc_d[0];
endmodule : lpc_far_model

// ===== test/lpc_ctrl_bench.sv
`timescale 1ns/10ps
module lpc_ctrl_bench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic stop_req = 1'b0, reduced_power_run = 1'b0, compute_op_request = 1'b0, compute_auto_exit = 1'b0;
    logic [1:0] stop_control_setting = 2'h0;
    logic [3:0] dma_wake_en = 4'h0, dma_req = 4'h0;
    logic wait_mode = 1'b0, stop_abort_clr = 1'b0, dma_busy = 1'b0, slow = 1'b0;
    logic irq_async_sys = 1'b0, irq_async_any = 1'b0, irq_sync_bus = 1'b0, irq_edge = 1'b0, irq_core_exc = 1'b0;
    logic [31:0] periph_doze_en = 32'h0000_0000;
    logic flash_doze_en = 1'b0;
    logic compute_op_acknowledge, stop_abort, in_low_power, irq_service_ok, mst_stop_req, mst_stop_ack;
    logic slv_stop_req, slv_stop_ack, bus_slv_stop_req, gen_low_req, pmc_low_req, pmc_ready;
    logic core_clk_en, sys_clk_en, bus_clk_en, bridge_space_err, flash_reg_en, io_port_input_valid;
    logic [31:0] periph_dozed;
    logic flash_dozed;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;

    lpc_ctrl #(.DMA_CH(4)) dut_u (.clk_sys, .reset_n, .stop_req, .stop_control_setting, .reduced_power_run,
        .compute_op_request, .compute_auto_exit, .dma_wake_en, .wait_mode, .compute_op_acknowledge, .stop_abort,
        .stop_abort_clr, .in_low_power, .irq_async_sys, .irq_async_any, .irq_sync_bus, .irq_edge, .irq_core_exc,
        .irq_service_ok, .dma_req, .dma_busy, .mst_stop_req, .mst_stop_ack, .slv_stop_req, .slv_stop_ack,
        .bus_slv_stop_req, .gen_low_req, .pmc_low_req, .pmc_ready, .core_clk_en, .sys_clk_en, .bus_clk_en,
        .bridge_space_err, .flash_reg_en, .io_port_input_valid, .periph_doze_en, .flash_doze_en, .periph_dozed,
        .flash_dozed);
    lpc_far_model far_u (.clk_sys, .mst_stop_req, .slv_stop_req, .pmc_low_req, .slow, .mst_stop_ack,
        .slv_stop_ack, .pmc_ready);

    always #2 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task summarize;
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // Whole run is a few hundred cycles; this only cuts a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask : chk

    task wait_lp(input logic v);
        for (int i = 0; i < 200 && in_low_power !== v; i++) @(negedge clk_sys);
        chk(in_low_power, v, "in_low_power");
    endtask : wait_lp

    task enter_stop(input logic [1:0] mode);
        stop_control_setting = mode;
        stop_req = 1'b1;
        for (int i = 0; i < 50 && mst_stop_req !== 1'b1; i++) @(negedge clk_sys);
        stop_req = 1'b0;
        for (int i = 0; i < 100 && sys_clk_en !== 1'b0; i++) @(negedge clk_sys);
        wait_lp(1'b1);
        repeat (2) @(negedge clk_sys);
    endtask : enter_stop

    ////////////////////////////////////////////////////////////////////////////////
    task test_bus_alive;
        enter_stop(lpc_pkg::STOP_BUS_ALIVE);
        chk({core_clk_en, sys_clk_en, bus_clk_en}, 3'b001, "clock enables");
        chk({mst_stop_req, slv_stop_req, bus_slv_stop_req, gen_low_req, pmc_low_req}, 5'h18, "stop reqs");
        irq_sync_bus = 1'b1;
        wait_lp(1'b0);
        irq_sync_bus = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({core_clk_en, sys_clk_en, bus_clk_en}, 3'b111, "clocks after exit");
    endtask : test_bus_alive

    task test_full_gate;
        enter_stop(lpc_pkg::STOP_FULL_GATE);
        chk({sys_clk_en, bus_clk_en, bus_slv_stop_req, gen_low_req}, 4'b0010, "full gate outputs");
        irq_sync_bus = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk(in_low_power, 1'b1, "sync irq ignored");
        irq_sync_bus = 1'b0;
        irq_async_any = 1'b1;
        wait_lp(1'b0);
        irq_async_any = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : test_full_gate

    task test_dma_wake;
        slow = 1'b1;
        dma_wake_en = 4'h4;
        enter_stop(lpc_pkg::STOP_FULL);
        chk(gen_low_req, 1'b1, "generator low");
        dma_req = 4'h1;
        repeat (10) @(negedge clk_sys);
        chk(sys_clk_en, 1'b0, "disabled channel ignored");
        dma_req = 4'h4;
        dma_busy = 1'b1;
        for (int i = 0; i < 100 && sys_clk_en !== 1'b1; i++) @(negedge clk_sys);
        repeat (2) @(negedge clk_sys);
        chk({core_clk_en, sys_clk_en, bus_clk_en, mst_stop_req, slv_stop_req}, 5'b01100, "woken state");
        dma_req = 4'h0;
        repeat (6) @(negedge clk_sys);
        chk(mst_stop_req, 1'b0, "waits for transfer end");
        dma_busy = 1'b0;
        for (int i = 0; i < 50 && mst_stop_req !== 1'b1; i++) @(negedge clk_sys);
        chk({mst_stop_req, slv_stop_req}, 2'b10, "masters before slaves");
        for (int i = 0; i < 100 && sys_clk_en !== 1'b0; i++) @(negedge clk_sys);
        wait_lp(1'b1);
        chk({sys_clk_en, gen_low_req}, 2'b01, "back in stop");
        irq_async_any = 1'b1;
        wait_lp(1'b0);
        irq_async_any = 1'b0;
        slow = 1'b0;
        dma_wake_en = 4'h0;
        repeat (6) @(negedge clk_sys);
    endtask : test_dma_wake

    task test_abort;
        dma_wake_en = 4'h1;
        stop_control_setting = lpc_pkg::STOP_BUS_ALIVE;
        stop_req = 1'b1;
        for (int i = 0; i < 50 && mst_stop_req !== 1'b1; i++) @(negedge clk_sys);
        stop_req = 1'b0;
        dma_req = 4'h1;
        repeat (2) @(negedge clk_sys);
        chk({stop_abort, mst_stop_req, sys_clk_en}, 3'b101, "entry aborted");
        dma_req = 4'h0;
        for (int i = 0; i < 100 && sys_clk_en !== 1'b0; i++) @(negedge clk_sys);
        chk(sys_clk_en, 1'b0, "entry restarted");
        dma_req = 4'h1;
        repeat (4) @(negedge clk_sys);
        chk({sys_clk_en, in_low_power}, 2'b11, "dma wakeup");
        irq_async_sys = 1'b1;
        wait_lp(1'b0);
        irq_async_sys = 1'b0;
        dma_req = 4'h0;
        dma_wake_en = 4'h0;
        stop_abort_clr = 1'b1;
        @(negedge clk_sys);
        stop_abort_clr = 1'b0;
        chk(stop_abort, 1'b0, "abort cleared");
        repeat (2) @(negedge clk_sys);
    endtask : test_abort

    task test_compute;
        for (int rp = 0; rp < 2; rp++) begin
            reduced_power_run = rp[0];
            compute_op_request = 1'b1;
            for (int i = 0; i < 100 && compute_op_acknowledge !== 1'b1; i++) @(negedge clk_sys);
            chk(compute_op_acknowledge, 1'b1, "ack on entry");
            chk({core_clk_en, mst_stop_req, slv_stop_req}, 3'b111, "compute clocks");
            chk({bridge_space_err, flash_reg_en}, 2'b10, "bridge and flash");
            chk(io_port_input_valid, 1'b0, "port input");
            chk(irq_service_ok, 1'b0, "level irq held");
            irq_edge = 1'b1;
            @(negedge clk_sys);
            chk(irq_service_ok, 1'b1, "edge irq serviced");
            irq_edge = 1'b0;
            stop_req = 1'b1;
            repeat (5) @(negedge clk_sys);
            chk({core_clk_en, compute_op_acknowledge}, 2'b11, "stop refused");
            stop_req = 1'b0;
            compute_op_request = 1'b0;
            repeat (2) @(negedge clk_sys);
            chk(compute_op_acknowledge, rp[0], "ack on exit");
            for (int i = 0; i < 60 && compute_op_acknowledge !== 1'b0; i++) @(negedge clk_sys);
            chk(compute_op_acknowledge, 1'b0, "ack after settle");
            repeat (4) @(negedge clk_sys);
        end
        reduced_power_run = 1'b0;
    endtask : test_compute

    task test_doze;
        periph_doze_en = 32'hA5A5_0003;
        flash_doze_en = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(periph_dozed, 32'h0000_0000, "no doze in run");
        wait_mode = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk({flash_dozed, periph_dozed}, {1'b1, 32'hA5A5_0003}, "doze in wait");
        wait_mode = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : test_doze

    initial begin
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        test_bus_alive();
        test_full_gate();
        test_dma_wake();
        test_abort();
        test_compute();
        test_doze();
        summarize();
    end
endmodule : lpc_ctrl_bench
